// >>> src/smm_supply_monitor.sv
// Top of the supply monitor mode logic
`timescale 1ns/1ps
module smm_supply_monitor #(
  parameter int BAT_DET_CYCLES  = smm_pkg::DET_CYCLES,
  parameter int BAT_REC_CYCLES  = smm_pkg::REC_CYCLES,
  parameter int CORE_DET_CYCLES = smm_pkg::DET_CYCLES,
  parameter int CORE_REC_CYCLES = smm_pkg::REC_CYCLES,
  parameter int IO_DET_CYCLES   = smm_pkg::DET_CYCLES,
  parameter int IO_REC_CYCLES   = smm_pkg::REC_CYCLES
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Comparator outputs, asynchronous
  input  wire logic                       batUnderVolt,
  input  wire logic                       coreUnderVolt,
  input  wire logic                       ioUnderVolt,
  input  wire logic                       batPowerDown,
  input  wire logic                       corePowerDown,
  // Host command
  input  wire logic                       cmdValid,
  input  wire logic [2:0]                 cmdMode,
  // Status read-out complete
  input  wire logic                       statusReadDone,
  // Status and mode outputs
  output logic [smm_pkg::STAT_W-1:0]      statusInfoReg,
  output logic                            errorStatusOut,
  output logic [2:0]                      operMode,
  output logic                            hostBlocked,
  output logic                            txEnable,
  output logic                            unpowered,
  // Sleep inhibit pin, driven high or released
  output logic                            sleepInhibitOut,
  output logic                            sleepInhibitOutEnN
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NIN = 5;
  logic [NIN-1:0] syncA;
  logic [NIN-1:0] syncB;
  logic [NIN-1:0] rawIn;

  assign rawIn = {corePowerDown, batPowerDown, ioUnderVolt,
                  coreUnderVolt, batUnderVolt};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  logic [smm_pkg::NSUP-1:0] uvLevel;
  logic                     powerDown;
  assign uvLevel   = syncB[2:0];
  assign powerDown = syncB[3] & syncB[4];

  // ----------------------------------------
  // Per-supply timers
  // ----------------------------------------
  logic [smm_pkg::NSUP-1:0] uvEvent;
  logic [smm_pkg::NSUP-1:0] uvFlag;

  localparam int DETS [smm_pkg::NSUP] =
    '{BAT_DET_CYCLES, CORE_DET_CYCLES, IO_DET_CYCLES};
  localparam int RECS [smm_pkg::NSUP] =
    '{BAT_REC_CYCLES, CORE_REC_CYCLES, IO_REC_CYCLES};

  genvar g;
  generate
    for (g = 0; g < smm_pkg::NSUP; g++) begin : gSup
      smm_supply_timer #(
        .DET_CYCLES (DETS[g]),
        .REC_CYCLES (RECS[g])
      ) uTimer (
        .core_clk  (core_clk),
        .rst       (rst),
        .underVolt (uvLevel[g]),
        .powerDown (powerDown),
        .uvEvent   (uvEvent[g]),
        .uvFlag    (uvFlag[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  smm_pkg::smm_mode_t mode;
  smm_pkg::smm_mode_t hostMode;
  smm_pkg::smm_mode_t next_mode;
  logic               blocked;
  logic               lowPowerForce;

  // I/O missing or core flag blocks the host interface
  assign blocked = uvLevel[smm_pkg::SUP_IO]
                 | uvFlag[smm_pkg::SUP_IO]
                 | uvFlag[smm_pkg::SUP_CORE];
  assign lowPowerForce = |uvFlag;

  // Last mode the host selected
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hostMode <= smm_pkg::MODE_STANDBY;
    end else if (powerDown) begin
      hostMode <= smm_pkg::MODE_STANDBY;
    end else if (cmdValid && !blocked) begin
      case (cmdMode)
        smm_pkg::MODE_SLEEP,
        smm_pkg::MODE_STANDBY,
        smm_pkg::MODE_NORMAL,
        smm_pkg::MODE_RXONLY,
        smm_pkg::MODE_GOSLEEP: begin
          hostMode <= smm_pkg::smm_mode_t'(cmdMode);
        end
        default: begin
          hostMode <= hostMode;
        end
      endcase
    end
  end

  always_comb begin
    next_mode = hostMode;
    if (powerDown) begin
      next_mode = smm_pkg::MODE_OFF;
    end else if (uvFlag[smm_pkg::SUP_BAT] || uvFlag[smm_pkg::SUP_IO]) begin
      next_mode = smm_pkg::MODE_SLEEP;
    end else if (uvFlag[smm_pkg::SUP_CORE]) begin
      next_mode = smm_pkg::MODE_STANDBY;
    end else if (uvLevel[smm_pkg::SUP_IO]) begin
      next_mode = smm_pkg::MODE_STANDBY;
    end
  end

  // Mode register keeps running during undervoltage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode <= smm_pkg::MODE_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic enterNormal;
  assign enterNormal = (next_mode == smm_pkg::MODE_NORMAL) &&
                       (mode != smm_pkg::MODE_NORMAL);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statusInfoReg <= smm_pkg::STAT_RESET;
    end else if (powerDown) begin
      statusInfoReg <= smm_pkg::STAT_RESET;
    end else begin
      if (statusReadDone || enterNormal) begin
        statusInfoReg <= smm_pkg::STAT_RESET;
      end
      // Set wins over clear
      if (uvEvent[smm_pkg::SUP_BAT]) begin
        statusInfoReg[smm_pkg::BAT_UV_BIT] <= 1'b1;
      end
      if (uvEvent[smm_pkg::SUP_CORE]) begin
        statusInfoReg[smm_pkg::CORE_UV_BIT] <= 1'b1;
      end
      if (uvEvent[smm_pkg::SUP_IO]) begin
        statusInfoReg[smm_pkg::IO_UV_BIT] <= 1'b1;
      end
      if (|uvEvent) begin
        statusInfoReg[smm_pkg::ERR_BIT] <= 1'b1;
      end
      if (uvLevel[smm_pkg::SUP_CORE]) begin
        statusInfoReg[smm_pkg::BUS_ERR_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  logic errShown;
  always_comb begin
    case (mode)
      smm_pkg::MODE_NORMAL,
      smm_pkg::MODE_RXONLY: begin
        errShown = statusInfoReg[smm_pkg::ERR_BIT];
      end
      default: begin
        errShown = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      errorStatusOut     <= 1'b1;
      operMode           <= 3'h2;
      hostBlocked        <= 1'b0;
      txEnable           <= 1'b0;
      unpowered          <= 1'b0;
      sleepInhibitOut    <= 1'b1;
      sleepInhibitOutEnN <= 1'b0;
    end else begin
      // Active-low error pin; I/O loss or power-down forces the error pin low
      errorStatusOut <= ~errShown & ~uvLevel[smm_pkg::SUP_IO]
                        & ~powerDown;
      operMode       <= next_mode;
      hostBlocked    <= blocked | powerDown;
      txEnable       <= (next_mode == smm_pkg::MODE_NORMAL)
                        & ~uvLevel[smm_pkg::SUP_CORE];
      unpowered      <= powerDown;
      sleepInhibitOut <= (next_mode != smm_pkg::MODE_SLEEP)
                         & ~powerDown;
      sleepInhibitOutEnN <= (next_mode == smm_pkg::MODE_SLEEP)
                            | powerDown;
    end
  end

endmodule : smm_supply_monitor

// >>> common/smm_pkg.sv
// Package of constants and types for the supply monitor mode logic
// Operation
// - Logic runs while either main supply is up
// - Missing I/O supply blocks commands, low power
// - Inhibit released only in sleep or off (unpowered) state
// - Logic keeps working during any undervoltage
// - Both main supplies down gives unpowered state
// - Unpowered state clears all status information
// - Error bit 11 set with any undervoltage bit
// - Error bit shown on error pin per mode
// - Undervoltage bits at positions 8, 9, 10
// - Undervoltage bits latched until power-down or clear
// - Undervoltage flags internal, steer modes and host blocking
// - Event sets bits and starts detection timer
// - Flag set if undervoltage remains at expiry
// - No flag if undervoltage clears during timer
// - Any active flag forces a low-power mode
// - Recovery timer expiry clears the flag
// - Relapse during recovery keeps flag set
// - All flags clear returns to commanded mode
// - Battery or I/O flag forces sleep state
// - Core flag blocks host, forces standby
// - Core undervoltage disables transmitter, sets bit 4
// - Status cleared on read-out or normal entry
package smm_pkg;

  // ----------------------------------------
  // Status register layout
  // ----------------------------------------
  localparam int STAT_W        = 16;
  localparam int BUS_ERR_BIT   = 4;
  localparam int BAT_UV_BIT    = 8;
  localparam int CORE_UV_BIT   = 9;
  localparam int IO_UV_BIT     = 10;
  localparam int ERR_BIT       = 11;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // ----------------------------------------
  // Supply indices
  // ----------------------------------------
  localparam int NSUP     = 3;
  localparam int SUP_BAT  = 0;
  localparam int SUP_CORE = 1;
  localparam int SUP_IO   = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int DET_TIME_US  = 100;
  localparam int REC_TIME_US  = 100;
  localparam int DET_CYCLES   = DET_TIME_US * CLK_MHZ;
  localparam int REC_CYCLES   = REC_TIME_US * CLK_MHZ;
  localparam int TMR_W        = 16;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_SLEEP    = 3'b001,
    MODE_STANDBY  = 3'b010,
    MODE_NORMAL   = 3'b011,
    MODE_RXONLY   = 3'b100,
    MODE_GOSLEEP  = 3'b101
  } smm_mode_t;

endpackage : smm_pkg

// >>> src/smm_supply_timer.sv
// Per-supply detection and recovery timer producing the undervoltage flag
`timescale 1ns/1ps
module smm_supply_timer #(
  parameter int DET_CYCLES = smm_pkg::DET_CYCLES,
  parameter int REC_CYCLES = smm_pkg::REC_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Synchronised undervoltage level
  input  wire logic underVolt,
  // Unpowered clear
  input  wire logic powerDown,
  // Outputs
  output logic      uvEvent,
  output logic      uvFlag
);

  localparam logic [smm_pkg::TMR_W-1:0] DET_LAST =
    smm_pkg::TMR_W'(DET_CYCLES - 1);
  localparam logic [smm_pkg::TMR_W-1:0] REC_LAST =
    smm_pkg::TMR_W'(REC_CYCLES - 1);

  logic                      underVoltQ;
  logic [smm_pkg::TMR_W-1:0] count;

  // ----------------------------------------
  // Edge of the undervoltage level
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      underVoltQ <= 1'b0;
    end else begin
      underVoltQ <= underVolt;
    end
  end

  assign uvEvent = underVolt & ~underVoltQ & ~powerDown;

  // ----------------------------------------
  // Detection and recovery counting
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count  <= '0;
      uvFlag <= 1'b0;
    end else if (powerDown) begin
      count  <= '0;
      uvFlag <= 1'b0;
    end else if (!uvFlag) begin
      if (!underVolt) begin
        count <= '0;
      end else if (count == DET_LAST) begin
        count  <= '0;
        uvFlag <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end else begin
      if (underVolt) begin
        count <= '0;
      end else if (count == REC_LAST) begin
        count  <= '0;
        uvFlag <= 1'b0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : smm_supply_timer

// >>> verif/smm_checker.sv
// Checker of the supply monitor mode logic ports
`timescale 1ns/1ps
module smm_checker #(
  parameter int BAT_DET_CYCLES  = 8,
  parameter int CORE_DET_CYCLES = 8
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Comparators
  input wire logic        batUnderVolt,
  input wire logic        coreUnderVolt,
  input wire logic        ioUnderVolt,
  input wire logic        batPowerDown,
  input wire logic        corePowerDown,
  // Outputs
  input wire logic [15:0] statusInfoReg,
  input wire logic        errorStatusOut,
  input wire logic [2:0]  operMode,
  input wire logic        hostBlocked,
  input wire logic        txEnable,
  input wire logic        unpowered,
  input wire logic        sleepInhibitOutEnN
);
  logic [15:0] batCnt;
  logic [15:0] coreCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Cycle counts while raw undervoltage is high
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      batCnt  <= 16'h0000;
      coreCnt <= 16'h0000;
    end else begin
      batCnt  <= batUnderVolt ? batCnt + 16'h0001 : 16'h0000;
      coreCnt <= coreUnderVolt ? coreCnt + 16'h0001 : 16'h0000;
    end
  end
  property p_err; (|statusInfoReg[10:8]) |-> statusInfoReg[11]; endproperty
  a_err: assert property (p_err) else $error("error bit missing");
  property p_inh; (operMode != smm_pkg::MODE_SLEEP &&
    operMode != smm_pkg::MODE_OFF) [*2] |-> !sleepInhibitOutEnN; endproperty
  a_inh: assert property (p_inh) else $error("inhibit released");
  property p_uvb; $rose(batUnderVolt) |-> ##[1:4] statusInfoReg[8];
  endproperty
  a_uvb: assert property (p_uvb) else $error("battery bit late");
  property p_unp; (batPowerDown && corePowerDown) [*4] |-> unpowered;
  endproperty
  a_unp: assert property (p_unp) else $error("not unpowered");
  property p_clr; unpowered && $past(unpowered) |-> statusInfoReg == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("status kept");
  property p_tx; coreUnderVolt [*4] |-> ##[0:2] (!txEnable &&
    statusInfoReg[4]); endproperty
  a_tx: assert property (p_tx) else $error("transmitter on");
  property p_blk; ioUnderVolt [*4] |-> ##[0:2] hostBlocked; endproperty
  a_blk: assert property (p_blk) else $error("host not blocked");
  property p_pin; (operMode == smm_pkg::MODE_NORMAL && statusInfoReg[11])
    [*2] |-> !errorStatusOut; endproperty
  a_pin: assert property (p_pin) else $error("error pin high");
  property p_slp; batCnt == BAT_DET_CYCLES + 4 && !unpowered |->
    ##[0:4] operMode == smm_pkg::MODE_SLEEP; endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  property p_stb; coreCnt == CORE_DET_CYCLES + 4 && !batUnderVolt &&
    !ioUnderVolt |-> ##[0:4] (operMode == smm_pkg::MODE_STANDBY &&
    hostBlocked); endproperty
  a_stb: assert property (p_stb) else $error("no standby");
endmodule : smm_checker

bind smm_supply_monitor smm_checker #(
  .BAT_DET_CYCLES(BAT_DET_CYCLES), .CORE_DET_CYCLES(CORE_DET_CYCLES)
) u_smm_checker (
  .core_clk(core_clk), .rst(rst), .batUnderVolt(batUnderVolt),
  .coreUnderVolt(coreUnderVolt), .ioUnderVolt(ioUnderVolt),
  .batPowerDown(batPowerDown), .corePowerDown(corePowerDown),
  .statusInfoReg(statusInfoReg), .errorStatusOut(errorStatusOut),
  .operMode(operMode), .hostBlocked(hostBlocked), .txEnable(txEnable),
  .unpowered(unpowered), .sleepInhibitOutEnN(sleepInhibitOutEnN)
);

// >>> verif/smm_host_model.sv
// Host model issuing mode commands and status read-outs
`timescale 1ns/1ps
module smm_host_model (
  // Clock
  input wire logic core_clk,
  // Host requests
  output logic       cmdValid,
  output logic [2:0] cmdMode,
  output logic       statusReadDone
);
  initial begin
    cmdValid       = 1'b0;
    cmdMode        = 3'h0;
    statusReadDone = 1'b0;
  end
  task automatic send(input logic [2:0] m);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdMode  <= m;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdMode  <= ~m;
  endtask : send
  task automatic readOut;
    @(posedge core_clk);
    statusReadDone <= 1'b1;
    @(posedge core_clk);
    statusReadDone <= 1'b0;
  endtask : readOut
endmodule : smm_host_model

// >>> verif/tb_supply_monitor_mode_logic.sv
// Testbench of the supply monitor mode logic
`timescale 1ns/1ps
module tb_supply_monitor_mode_logic;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        batUv = 1'b0;
  logic        coreUv = 1'b0;
  logic        ioUv = 1'b0;
  logic        batPd = 1'b0;
  logic        corePd = 1'b0;
  logic        cmdValid;
  logic [2:0]  cmdMode;
  logic        readDone;
  logic [15:0] stat;
  logic        errPin;
  logic [2:0]  operMode;
  logic        blocked;
  logic        txEn;
  logic        unpowered;
  logic        inhEnN;
  logic        inhOut;
  int          checks = 0;
  int          mismatches = 0;
  logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  smm_host_model u_smm_host_model (.core_clk(core_clk), .cmdValid(cmdValid),
    .cmdMode(cmdMode), .statusReadDone(readDone));
  smm_supply_monitor #(.BAT_DET_CYCLES(8), .BAT_REC_CYCLES(8),
    .CORE_DET_CYCLES(8), .CORE_REC_CYCLES(8)) u_smm_supply_monitor (
    .core_clk(core_clk),
    .rst(rst), .batUnderVolt(batUv), .coreUnderVolt(coreUv),
    .ioUnderVolt(ioUv), .batPowerDown(batPd), .corePowerDown(corePd),
    .cmdValid(cmdValid), .cmdMode(cmdMode), .statusReadDone(readDone),
    .statusInfoReg(stat), .errorStatusOut(errPin), .operMode(operMode),
    .hostBlocked(blocked), .txEnable(txEn), .unpowered(unpowered),
    .sleepInhibitOut(inhOut), .sleepInhibitOutEnN(inhEnN));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic sup(input logic [4:0] v);
    @(posedge core_clk);
    {batUv, coreUv, ioUv, batPd, corePd} <= v;
  endtask : sup
  task automatic waitMode(input logic [2:0] m);
    for (int i = 0; i < 4100 && operMode !== m; i++) tick(1);
    chk({13'h0000, operMode}, {13'h0000, m});
    if (operMode !== m) print_verdict();
  endtask : waitMode
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk(stat, 16'h0000);
    waitMode(3'h2);
    foreach (codes[i]) begin
      u_smm_host_model.send(codes[i]);
      waitMode(codes[i]);
      tick(1);
      chk({15'h0000, inhEnN}, {15'h0000, codes[i] == 3'h1});
      chk({15'h0000, inhOut}, {15'h0000, codes[i] != 3'h1});
    end
    u_smm_host_model.send(3'h7);
    tick(4);
    waitMode(3'h3);
    sup(5'b10000);
    tick(4);
    sup(5'b00000);
    tick(12);
    chk(stat, 16'h0900);
    chk({15'h0000, errPin}, 16'h0000);
    waitMode(3'h3);
    u_smm_host_model.readOut();
    tick(2);
    chk(stat, 16'h0000);
    sup(5'b10000);
    waitMode(3'h1);
    u_smm_host_model.send(3'h4);
    sup(5'b00000);
    tick(4);
    sup(5'b10000);
    tick(6);
    waitMode(3'h1);
    sup(5'b00000);
    waitMode(3'h4);
    chk(stat, 16'h0900);
    sup(5'b01000);
    waitMode(3'h2);
    u_smm_host_model.send(3'h3);
    chk(stat & 16'h0210, 16'h0210);
    sup(5'b00000);
    waitMode(3'h4);
    sup(5'b00100);
    tick(5);
    chk({15'h0000, blocked}, 16'h0001);
    waitMode(3'h1);
    sup(5'b00000);
    waitMode(3'h4);
    sup(5'b00111);
    tick(6);
    chk({15'h0000, unpowered}, 16'h0001);
    chk(stat, 16'h0000);
    sup(5'b00001);
    tick(6);
    chk({15'h0000, unpowered}, 16'h0000);
    waitMode(3'h2);
    print_verdict();
  end
endmodule : tb_supply_monitor_mode_logic
